// [logic/dpm_monitor.sv]
`timescale 1ns/1ps
// Behaviour
// - Feedback check armed only above EMF level.
// - EMF versus speed difference trips feedback loss.
// - Stall level is percent of rated current.
// - Stall level zero disables stall protection.
// - Low field current past delay trips.
// - Field loss reset needs general enable off.
// - Low line voltage past delay trips.
// - Undervoltage delay sixty seconds disables protection.
// - Armature overvoltage over two seconds trips.
// - Field overcurrent over two seconds trips.
// - Line overvoltage over five seconds trips.
// - Phase difference over limit two seconds trips.
// - Unbalance limit zero disables unbalance protection.
// - Line frequency outside band trips.
// - External field frequency outside band trips.
// - High torque at low speed trips stall.
module dpm_monitor
  import dpm_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] emf_v,
  input wire logic [7:0] speed_fb_pct,
  input wire logic [15:0] speed_rpm,
  input wire logic [15:0] torque_i,
  input wire logic [15:0] field_i,
  input wire logic [15:0] arm_v,
  input wire logic [15:0] line_v,
  input wire logic [15:0] line_r_v,
  input wire logic [15:0] line_s_v,
  input wire logic [15:0] line_t_v,
  input wire logic [15:0] line_freq,
  input wire logic [15:0] field_freq,
  output logic converter_disable,
  output logic [3:0] fault_code
);
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic aw_got_r, w_got_r;
  logic [AW-1:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  dpm_ws_t ws_r;
  logic [3:0] ctrl_r;
  logic [31:0] cfg_r [CFG_LO:CFG_HI];
  logic [NF-1:0] fault_r, cond_r, hit;
  logic [3:0] code_r;
  logic dis_r;
  logic [TICK_W-1:0] tick_cnt_r;
  logic tick_r;

  logic aw_take, w_take, do_wr, ar_take, wr_ok, freset, reset_ok;
  logic [AW-1:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic [3:0] widx, ridx;
  logic [31:0] rd_nxt;

  // Percent scaled product; 26 bits hold any 16-bit value times 255 %.
  function automatic logic [25:0] mulp(input logic [15:0] a, input logic [8:0] p);
    mulp = 26'(a) * 26'(p);
  endfunction

  function automatic logic [15:0] absd(input logic [15:0] a, input logic [15:0] b);
    absd = (a > b) ? a - b : b - a;
  endfunction

  // Write channel: address and data are taken in either order.
  assign aw_take = s_axi_awvalid && awready_r;
  assign w_take = s_axi_wvalid && wready_r;
  assign do_wr = (aw_got_r || aw_take) && (w_got_r || w_take) && (ws_r == DPM_WS_IDLE);
  assign wa = aw_got_r ? aw_addr_r : s_axi_awaddr;
  assign wd = w_got_r ? w_data_r : s_axi_wdata;
  assign ws = w_got_r ? w_strb_r : s_axi_wstrb;
  assign widx = wa[5:2];
  assign wr_ok = (wa[AW-1:6] == '0) && (widx <= IX_LIVE);
  assign freset = do_wr && wr_ok && widx == IX_CTRL && ws[0] && wd[CT_FRESET];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end
    else
    begin
      aw_got_r <= do_wr ? 1'b0 : (aw_got_r || aw_take);
      w_got_r <= do_wr ? 1'b0 : (w_got_r || w_take);
      awready_r <= do_wr || !(aw_got_r || aw_take);
      wready_r <= do_wr || !(w_got_r || w_take);
      if (aw_take)
        aw_addr_r <= s_axi_awaddr;
      if (w_take)
      begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ws_r <= DPM_WS_IDLE;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end
    else
    begin
      case (ws_r)
        DPM_WS_IDLE:
          if (do_wr)
          begin
            ws_r <= DPM_WS_RESP;
            bvalid_r <= 1'b1;
            bresp_r <= wr_ok ? RESP_OKAY : RESP_SLVERR;
          end
        DPM_WS_RESP:
          if (s_axi_bready)
          begin
            ws_r <= DPM_WS_IDLE;
            bvalid_r <= 1'b0;
          end
        default:
        begin
          ws_r <= DPM_WS_IDLE;
          bvalid_r <= 1'b0;
        end
      endcase
    end
  end

  // Control bits; the fault reset bit is a strobe and is never stored.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_r <= CTRL_RST;
    else if (do_wr && wr_ok && widx == IX_CTRL && ws[0])
      ctrl_r <= wd[3:0] & ~(4'h1 << CT_FRESET);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = CFG_LO; i <= CFG_HI; i++)
        cfg_r[i] <= CFG_RST[i];
    end
    else if (do_wr && wr_ok)
    begin
      for (int i = CFG_LO; i <= CFG_HI; i++)
        for (int b = 0; b < 4; b++)
          if (widx == 4'(i) && ws[b])
            cfg_r[i][b*8 +: 8] <= wd[b*8 +: 8];
    end
  end

  // Read channel: one read at a time, data registered at the handshake.
  assign ar_take = s_axi_arvalid && arready_r;
  assign ridx = s_axi_araddr[5:2];

  always_comb
  begin
    rd_nxt = '0;
    if (ridx == IX_CTRL)
      rd_nxt[3:0] = ctrl_r;
    else if (ridx == IX_STAT)
      rd_nxt = {11'h000, dis_r, code_r, 6'h00, fault_r};
    else if (ridx == IX_LIVE)
      rd_nxt[NF-1:0] = cond_r;
    else if (ridx >= 4'(CFG_LO) && ridx <= 4'(CFG_HI))
      rd_nxt = cfg_r[ridx];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end
    else
    begin
      arready_r <= !(ar_take || (rvalid_r && !s_axi_rready));
      if (ar_take)
      begin
        rvalid_r <= 1'b1;
        if (s_axi_araddr[AW-1:6] == '0 && ridx <= IX_LIVE)
        begin
          rdata_r <= rd_nxt;
          rresp_r <= RESP_OKAY;
        end
        else
        begin
          rdata_r <= '0;
          rresp_r <= RESP_SLVERR;
        end
      end
      else if (s_axi_rready)
        rvalid_r <= 1'b0;
    end
  end

  // Time base for all persistence delays.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= (tick_cnt_r == TICK_W'(TICK_CYC - 1));
      tick_cnt_r <= (tick_cnt_r == TICK_W'(TICK_CYC - 1)) ? '0 : tick_cnt_r + 1'b1;
    end
  end

  // Setting fields.
  logic [15:0] rated_line, rated_motor, rated_conv, rated_fld, freq_rat;
  logic [7:0] fdev;
  assign rated_line = cfg_r[IX_RATED][L16 +: 16];
  assign rated_motor = cfg_r[IX_RATED][H16 +: 16];
  assign rated_conv = cfg_r[IX_RATED2][L16 +: 16];
  assign rated_fld = cfg_r[IX_RATED2][H16 +: 16];
  assign fdev = cfg_r[IX_MISC][B1 +: 8];
  assign freq_rat = ctrl_r[CT_LINE60] ? FREQ60 : FREQ50;

  // Conditions are compared in scaled integers to avoid any division.
  logic [NF-1:0] cond_nxt;
  logic [7:0] stall_lvl, unbal_lim, uv_s, arm_m, fo_m, lo_m, uv_m;
  assign stall_lvl = cfg_r[IX_STALL][B0 +: 8];
  assign unbal_lim = cfg_r[IX_LINE][B3 +: 8];
  assign uv_s = cfg_r[IX_LINE][B1 +: 8];
  assign uv_m = cfg_r[IX_LINE][B0 +: 8];
  assign lo_m = cfg_r[IX_LINE][B2 +: 8];
  assign arm_m = cfg_r[IX_MISC][B0 +: 8];
  assign fo_m = cfg_r[IX_FIELD][B3 +: 8];

  always_comb
  begin
    cond_nxt = '0;
    cond_nxt[F_FB] = (emf_v > cfg_r[IX_EMF][L16 +: 16]) &&
      ((mulp(emf_v, PCT_FULL) > mulp(rated_motor, {1'b0, speed_fb_pct})
        ? mulp(emf_v, PCT_FULL) - mulp(rated_motor, {1'b0, speed_fb_pct})
        : mulp(rated_motor, {1'b0, speed_fb_pct}) - mulp(emf_v, PCT_FULL))
        > mulp(rated_motor, {1'b0, cfg_r[IX_EMF][B2 +: 8]}));
    cond_nxt[F_STALL] = (stall_lvl != 8'h00) &&
      (mulp(torque_i, PCT_FULL) > mulp(rated_conv, {1'b0, stall_lvl})) &&
      (speed_rpm < cfg_r[IX_STALL][H16 +: 16]);
    cond_nxt[F_FLOSS] = field_i < cfg_r[IX_FIELD][L16 +: 16];
    cond_nxt[F_UV] = (uv_s < UV_OFF_S) &&
      (mulp(line_v, PCT_FULL) < mulp(rated_line, PCT_FULL - {1'b0, uv_m}));
    cond_nxt[F_ARMOV] = (arm_m != 8'h00) &&
      (mulp(arm_v, PCT_FULL) > mulp(rated_motor, PCT_FULL + {1'b0, arm_m}));
    cond_nxt[F_FLDOC] = (fo_m != 8'h00) &&
      (mulp(field_i, PCT_FULL) > mulp(rated_fld, PCT_FULL + {1'b0, fo_m}));
    cond_nxt[F_LINEOV] = (lo_m != 8'h00) &&
      (mulp(line_v, PCT_FULL) > mulp(rated_line, PCT_FULL + {1'b0, lo_m}));
    cond_nxt[F_UNBAL] = (unbal_lim != 8'h00) &&
      ((mulp(absd(line_r_v, line_s_v), PCT_FULL) > mulp(rated_line, {1'b0, unbal_lim})) ||
       (mulp(absd(line_s_v, line_t_v), PCT_FULL) > mulp(rated_line, {1'b0, unbal_lim})) ||
       (mulp(absd(line_r_v, line_t_v), PCT_FULL) > mulp(rated_line, {1'b0, unbal_lim})));
    cond_nxt[F_LFREQ] =
      (mulp(line_freq, PCT_FULL) > mulp(freq_rat, PCT_FULL + {1'b0, fdev})) ||
      (mulp(line_freq, PCT_FULL) < mulp(freq_rat, PCT_FULL - {1'b0, fdev}));
    cond_nxt[F_FFREQ] = ctrl_r[CT_FLD_EXT] &&
      ((mulp(field_freq, PCT_FULL) > mulp(freq_rat, PCT_FULL + {1'b0, fdev})) ||
       (mulp(field_freq, PCT_FULL) < mulp(freq_rat, PCT_FULL - {1'b0, fdev})));
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cond_r <= '0;
    else
      cond_r <= cond_nxt;
  end

  // Delays in time base ticks; the undervoltage delay is set in whole seconds.
  logic [PT_W-1:0] dly [NF];
  assign dly[F_FB] = '0;
  assign dly[F_STALL] = PT_W'(cfg_r[IX_STALL][B1 +: 8]);
  assign dly[F_FLOSS] = PT_W'(cfg_r[IX_FIELD][B2 +: 8]);
  assign dly[F_UV] = PT_W'(PT_W'(uv_s) * TICKS_PER_S);
  assign dly[F_ARMOV] = ARM_OV_TICKS;
  assign dly[F_FLDOC] = FLD_OC_TICKS;
  assign dly[F_LINEOV] = LINE_OV_TICKS;
  assign dly[F_UNBAL] = UNBAL_TICKS;
  assign dly[F_LFREQ] = '0;
  assign dly[F_FFREQ] = '0;

  generate
    for (genvar g = 0; g < NF; g++)
    begin : g_tmr
      dpm_persist u_tmr (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick_r),
        .cond(cond_r[g]),
        .dly(dly[g]),
        .expired(hit[g])
      );
    end
  endgenerate

  // A reset is refused while a field loss is latched and general enable stands.
  assign reset_ok = freset && !(fault_r[F_FLOSS] && ctrl_r[CT_GEN_EN]);

  // A trip arriving with an accepted reset wins over the clear.
  logic [3:0] first_code;
  always_comb
  begin
    first_code = 4'h0;
    for (int i = NF - 1; i >= 0; i--)
      if (hit[i])
        first_code = 4'(i + 1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fault_r <= '0;
      code_r <= 4'h0;
      dis_r <= 1'b0;
    end
    else
    begin
      fault_r <= (reset_ok ? '0 : fault_r) | hit;
      if ((reset_ok || code_r == 4'h0) && hit != '0)
        code_r <= first_code;
      else if (reset_ok)
        code_r <= 4'h0;
      dis_r <= (reset_ok ? 1'b0 : dis_r) | (hit != '0);
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign converter_disable = dis_r;
  assign fault_code = code_r;
endmodule

// [logic/dpm_pkg.sv]
package dpm_pkg;
  // Clock rate and the persistence time base.
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICK_W = 25;
  // Fixed persistence times, in ms, and their counts in time base ticks.
  localparam int unsigned ARM_OV_TIME_MS = 2000;
  localparam int unsigned FLD_OC_TIME_MS = 2000;
  localparam int unsigned LINE_OV_TIME_MS = 5000;
  localparam int unsigned UNBAL_TIME_MS = 2000;
  localparam int unsigned PT_W = 10;
  localparam logic [PT_W-1:0] ARM_OV_TICKS = PT_W'(ARM_OV_TIME_MS / TICK_MS);
  localparam logic [PT_W-1:0] FLD_OC_TICKS = PT_W'(FLD_OC_TIME_MS / TICK_MS);
  localparam logic [PT_W-1:0] LINE_OV_TICKS = PT_W'(LINE_OV_TIME_MS / TICK_MS);
  localparam logic [PT_W-1:0] UNBAL_TICKS = PT_W'(UNBAL_TIME_MS / TICK_MS);
  localparam logic [PT_W-1:0] TICKS_PER_S = PT_W'(1000 / TICK_MS);
  localparam logic [7:0] UV_OFF_S = 8'h3C;
  // Percent arithmetic and rated line frequencies in 0.01 Hz.
  localparam logic [8:0] PCT_FULL = 9'h064;
  localparam logic [15:0] FREQ50 = 16'h1388;
  localparam logic [15:0] FREQ60 = 16'h1770;
  // Register word indices; byte address is four times the index.
  localparam int unsigned AW = 8;
  localparam logic [3:0] IX_CTRL = 4'h0;
  localparam logic [3:0] IX_STAT = 4'h1;
  localparam logic [3:0] IX_EMF = 4'h2;
  localparam logic [3:0] IX_STALL = 4'h3;
  localparam logic [3:0] IX_FIELD = 4'h4;
  localparam logic [3:0] IX_LINE = 4'h5;
  localparam logic [3:0] IX_RATED = 4'h6;
  localparam logic [3:0] IX_RATED2 = 4'h7;
  localparam logic [3:0] IX_MISC = 4'h8;
  localparam logic [3:0] IX_LIVE = 4'h9;
  localparam int unsigned CFG_LO = 2;
  localparam int unsigned CFG_HI = 8;
  // Field positions: a 16-bit field at L16/H16, byte fields at B0..B3.
  localparam int unsigned L16 = 0;
  localparam int unsigned H16 = 16;
  localparam int unsigned B0 = 0;
  localparam int unsigned B1 = 8;
  localparam int unsigned B2 = 16;
  localparam int unsigned B3 = 24;
  localparam int unsigned CT_GEN_EN = 0;
  localparam int unsigned CT_FRESET = 1;
  localparam int unsigned CT_FLD_EXT = 2;
  localparam int unsigned CT_LINE60 = 3;
  localparam int unsigned ST_CODE = 16;
  localparam int unsigned ST_DIS = 20;
  // Values after reset.
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [31:0] CFG_RST [CFG_LO:CFG_HI] = '{
    32'h0019_0032,  // diff 25 %, EMF level 50 V
    32'h0012_1405,  // stall speed 18 rpm, delay 2.0 s, level 5 %
    32'h0A14_000A,  // field OC 10 %, loss delay 2.0 s, min current 10
    32'h0F14_030F,  // unbalance 15 %, line OV 20 %, UV delay 3 s, UV 15 %
    32'h01CC_0190,  // motor rated 460 V, line rated 400 V
    32'h000A_0064,  // rated field current 10, converter rated 100
    32'h0000_050A   // frequency band 5 %, armature OV 10 %
  };
  // Fault indices; the fault code is index plus one.
  localparam int unsigned NF = 10;
  localparam int unsigned F_FB = 0;
  localparam int unsigned F_STALL = 1;
  localparam int unsigned F_FLOSS = 2;
  localparam int unsigned F_UV = 3;
  localparam int unsigned F_ARMOV = 4;
  localparam int unsigned F_FLDOC = 5;
  localparam int unsigned F_LINEOV = 6;
  localparam int unsigned F_UNBAL = 7;
  localparam int unsigned F_LFREQ = 8;
  localparam int unsigned F_FFREQ = 9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {DPM_WS_IDLE = 2'h0, DPM_WS_RESP = 2'h1} dpm_ws_t;
endpackage

// [logic/dpm_persist.sv]
`timescale 1ns/1ps
module dpm_persist
  import dpm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tick,
  input wire logic cond,
  input wire logic [PT_W-1:0] dly,
  output logic expired
);
  logic [PT_W-1:0] cnt_r;

  // An interrupted condition starts the delay over, so only a steady one trips.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_r <= '0;
    else if (!cond)
      cnt_r <= '0;
    else if (tick && cnt_r != '1)
      cnt_r <= cnt_r + 1'b1;
  end

  // Strictly longer than the delay; a zero delay trips at once.
  assign expired = cond && (dly == '0 || cnt_r > dly);
endmodule

// [bench/dpm_monitor_sva.sv]
`timescale 1ns/1ps
module dpm_monitor_sva
  import dpm_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic [15:0] emf_v,
  input wire logic [7:0] speed_fb_pct,
  input wire logic [15:0] arm_v,
  input wire logic [15:0] line_v,
  input wire logic [15:0] line_freq,
  input wire logic converter_disable,
  input wire logic [3:0] fault_code
);
  logic [2:0] since_clr_r;
  logic [15:0] aov_cnt_r;
  logic [15:0] lov_cnt_r;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Any write carrying the clear bit may legally drop a fault, so hold checks wait it out.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (s_axi_wvalid && s_axi_wready && s_axi_wdata[1]))
      since_clr_r <= 3'h0;
    else if (since_clr_r != 3'h7)
      since_clr_r <= since_clr_r + 3'h1;
  end
  // Thresholds assume the default ratings and margins held by the bench.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || arm_v <= 16'h01FA)
      aov_cnt_r <= 16'h0000;
    else if (aov_cnt_r != 16'hFFFF)
      aov_cnt_r <= aov_cnt_r + 16'h0001;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || line_v <= 16'h01E0)
      lov_cnt_r <= 16'h0000;
    else if (lov_cnt_r != 16'hFFFF)
      lov_cnt_r <= lov_cnt_r + 16'h0001;
  end
  a_code_disable_pair: assert property (converter_disable == (fault_code != 4'h0))
    else $error("disable and fault code disagree");
  a_fault_holds: assert property (
    fault_code != 4'h0 ##1 since_clr_r == 3'h7 |-> $stable(fault_code))
    else $error("latched fault changed without a clear");
  a_fb_trip: assert property (
    (emf_v >= 16'h00C8 && speed_fb_pct == 8'h00) [*3] |=> converter_disable)
    else $error("feedback loss did not disable");
  a_freq_trip: assert property ((line_freq >= 16'h189D) [*3] |=> converter_disable)
    else $error("line frequency out of band did not disable");
  a_armov_persist: assert property (
    fault_code == 4'h5 && $past(fault_code) != 4'h5 |-> aov_cnt_r >= ARM_OV_TICKS * TICK_CYC)
    else $error("armature overvoltage tripped too early");
  a_lineov_persist: assert property (
    fault_code == 4'h7 && $past(fault_code) != 4'h7 |-> lov_cnt_r >= LINE_OV_TICKS * TICK_CYC)
    else $error("line overvoltage tripped too early");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  cover property (fault_code == 4'h3);
  cover property (fault_code == 4'h7);
  cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
bind dpm_monitor dpm_monitor_sva #(.TICK_CYC(TICK_CYC)) i_sva (
  .aclk, .aresetn, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .emf_v, .speed_fb_pct,
  .arm_v, .line_v, .line_freq, .converter_disable, .fault_code
);

// [bench/dpm_meas.sv]
`timescale 1ns/1ps
// Readings sit at rated values; sel 1 to 10 provoke faults 1 to 10, and sel 11 sets a feedback mismatch below the EMF level.
module dpm_meas
  import dpm_pkg::*;
(
  input wire logic [3:0] sel,
  output logic [15:0] emf_v,
  output logic [7:0] speed_fb_pct,
  output logic [15:0] speed_rpm,
  output logic [15:0] torque_i,
  output logic [15:0] field_i,
  output logic [15:0] arm_v,
  output logic [15:0] line_v,
  output logic [15:0] line_r_v,
  output logic [15:0] line_s_v,
  output logic [15:0] line_t_v,
  output logic [15:0] line_freq,
  output logic [15:0] field_freq
);
  assign emf_v = (sel == 4'h1) ? 16'h00C8 : (sel == 4'hB) ? 16'h0028 : 16'h0000;
  assign speed_fb_pct = (sel == 4'hB) ? 8'h64 : 8'h00;
  assign speed_rpm = (sel == 4'h2) ? 16'h0000 : 16'h0064;
  assign torque_i = (sel == 4'h2) ? 16'h000A : 16'h0000;
  assign field_i = (sel == 4'h3) ? 16'h0005 : (sel == 4'h6) ? 16'h0014 : 16'h000A;
  assign arm_v = (sel == 4'h5) ? 16'h0258 : 16'h01CC;
  assign line_v = (sel == 4'h4) ? 16'h012C : (sel == 4'h7) ? 16'h01F4 : 16'h0190;
  assign line_r_v = (sel == 4'h8) ? 16'h01F4 : 16'h0190;
  assign line_s_v = 16'h0190;
  assign line_t_v = 16'h0190;
  assign line_freq = (sel == 4'h9) ? 16'h1964 : 16'h1388;
  assign field_freq = (sel == 4'hA) ? 16'h1964 : 16'h1388;
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
  import dpm_pkg::*;
  // A short time base keeps each persistence delay to a few hundred cycles.
  localparam int unsigned TC = 10;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic converter_disable;
  logic [AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, fault_code, sel;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] emf_v, speed_rpm, torque_i, field_i, arm_v, line_v;
  logic [15:0] line_r_v, line_s_v, line_t_v, line_freq, field_freq;
  logic [7:0] speed_fb_pct;
  int mismatches, n_compared, cyc;
  dpm_monitor #(.TICK_CYC(TC)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .emf_v, .speed_fb_pct, .speed_rpm, .torque_i, .field_i, .arm_v, .line_v,
    .line_r_v, .line_s_v, .line_t_v, .line_freq, .field_freq, .converter_disable, .fault_code
  );
  dpm_meas i_meas (
    .sel, .emf_v, .speed_fb_pct, .speed_rpm, .torque_i, .field_i, .arm_v, .line_v,
    .line_r_v, .line_s_v, .line_t_v, .line_freq, .field_freq
  );
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta;
    logic tw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    ta = 1'b0;
    tw = 1'b0;
    while (!(ta && tw))
    begin
      @(posedge aclk);
      if (!ta && s_axi_awready === 1'b1)
      begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!tw && s_axi_wready === 1'b1)
      begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = CFG_LO; i <= CFG_HI; i++)
    begin
      rd(8'(i * 4), d, r);
      chk("config reset value", d, CFG_RST[i]);
    end
    rd(8'h40, d, r);
    chk("unmapped read data", d, 32'h0);
    chk("unmapped read resp", 32'(r), 32'(RESP_SLVERR));
    wr(8'h24, 32'hFFFF_FFFF, r);
    chk("read-only write resp", 32'(r), 32'(RESP_OKAY));
    $display("test regs done");
  endtask
  task automatic t_trips;
    int d [1:10] = '{0, 20, 20, 30, 20, 20, 50, 20, 0, 0};
    int n;
    logic [1:0] r;
    wr(8'h00, 32'h4, r);
    for (int k = 1; k <= 10; k++)
    begin
      @(posedge aclk);
      sel <= 4'(k);
      n = 0;
      while (converter_disable !== 1'b1 && n < 800)
      begin
        @(posedge aclk);
        n++;
      end
      chk("fault code", 32'(fault_code), 32'(k));
      chk("trip delay", 32'(n >= d[k] * TC && n <= (d[k] + 2) * TC + 4), 32'h1);
      sel <= 4'h0;
      repeat (4) @(posedge aclk);
      chk("fault code held", 32'(fault_code), 32'(k));
      wr(8'h00, 32'h6, r);
      repeat (3) @(posedge aclk);
      chk("fault cleared", 32'(fault_code), 32'h0);
    end
    $display("test trips done");
  endtask
  task automatic t_restart;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    sel <= 4'h3;
    repeat (15 * TC) @(posedge aclk);
    sel <= 4'h0;
    repeat (3) @(posedge aclk);
    sel <= 4'h3;
    repeat (15 * TC) @(posedge aclk);
    chk("no trip across gap", 32'(fault_code), 32'h0);
    rd(8'h24, d, r);
    chk("live field loss condition", d, 32'h0000_0004);
    sel <= 4'h0;
    $display("test restart done");
  endtask
  task automatic t_fl_reset;
    logic [1:0] r;
    logic [31:0] d;
    wr(8'h00, 32'h5, r);
    @(posedge aclk);
    sel <= 4'h3;
    repeat (25 * TC) @(posedge aclk);
    sel <= 4'h0;
    chk("field loss trip", 32'(fault_code), 32'h3);
    rd(8'h04, d, r);
    chk("status word", d, 32'h0013_0004);
    wr(8'h00, 32'h7, r);
    repeat (3) @(posedge aclk);
    chk("clear while enabled", 32'(fault_code), 32'h3);
    rd(8'h00, d, r);
    chk("control after refused clear", d, 32'h0000_0005);
    wr(8'h00, 32'h4, r);
    wr(8'h00, 32'h6, r);
    repeat (3) @(posedge aclk);
    chk("clear when disabled", 32'(fault_code), 32'h0);
    // A 50 Hz reading is outside the 60 Hz band, and the clear races the live trip.
    wr(8'h00, 32'hC, r);
    repeat (4) @(posedge aclk);
    chk("sixty hertz band", 32'(fault_code), 32'h9);
    wr(8'h00, 32'h6, r);
    chk("trip beats clear", 32'(fault_code), 32'h9);
    wr(8'h00, 32'h6, r);
    repeat (3) @(posedge aclk);
    chk("clear after band restored", 32'(fault_code), 32'h0);
    $display("test field loss reset done");
  endtask
  task automatic t_off;
    logic [7:0] a [7] = '{8'h0C, 8'h14, 8'h20, 8'h10, 8'h14, 8'h14, 8'h08};
    logic [31:0] v [7] = '{32'h0012_1400, 32'h0F14_3C0F, 32'h0000_0500, 32'h0014_000A,
      32'h0F00_030F, 32'h0014_030F, 32'h0019_0032};
    logic [3:0] s [7] = '{4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hB};
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 7; i++)
    begin
      wr(a[i], v[i], r);
      rd(a[i], d, r);
      chk("config write", d, v[i]);
      @(posedge aclk);
      sel <= s[i];
      // Longer than the sixty second undervoltage delay, so a live timer would trip.
      repeat (610 * TC) @(posedge aclk);
      sel <= 4'h0;
      chk("no trip when disabled", 32'(fault_code), 32'h0);
      wr(a[i], CFG_RST[a[i] / 4], r);
    end
    $display("test disabled checks done");
  endtask
  initial
  begin
    aresetn = 1'b0;
    sel = 4'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    chk("no fault at rated values", 32'(fault_code), 32'h0);
    t_trips();
    t_restart();
    t_fl_reset();
    t_off();
    give_verdict();
  end
endmodule
